// ### src/fault_blink_pkg.sv
// constants and types shared by the fault blink-code indicator and its helpers
// assumes a single 250 MHz system clock; all times are derived from it here
package fault_blink_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // lamp timing, in milliseconds
  localparam int unsigned PULSE_ON_MS = 150;
  localparam int unsigned PULSE_OFF_MS = 150;
  localparam int unsigned DIGIT_GAP_MS = 500;
  localparam int unsigned CODE_GAP_MS = 1000;
  localparam int unsigned START_BLINK_MS = 250;

  // lamp timing, in clock cycles
  localparam int unsigned PULSE_ON_CYC = PULSE_ON_MS * CYC_PER_MS;
  localparam int unsigned PULSE_OFF_CYC = PULSE_OFF_MS * CYC_PER_MS;
  localparam int unsigned DIGIT_GAP_CYC = DIGIT_GAP_MS * CYC_PER_MS;
  localparam int unsigned CODE_GAP_CYC = CODE_GAP_MS * CYC_PER_MS;
  localparam int unsigned START_BLINK_CYC = START_BLINK_MS * CYC_PER_MS;

  // widths and sizes
  localparam int unsigned TIMER_W = 32;
  localparam int unsigned CODE_DIGITS = 4;
  localparam int unsigned DIGIT_W = 4;
  localparam int unsigned CODE_W = CODE_DIGITS * DIGIT_W;
  localparam int unsigned HIST_DEPTH = 16;
  localparam int unsigned COUNT_W = 8;

  // encodings and reset values
  localparam logic [3:0] ZERO_DIGIT_PULSES = 4'ha;
  localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_ON = 3'h1,
    SEQ_OFF = 3'h3,
    SEQ_DGAP = 3'h2,
    SEQ_CGAP = 3'h6
  } lamp_seq_t;

endpackage

// ### src/interval_timer.sv
// down-counting interval timer: o_done pulses in the last cycle of a loaded interval
// assumes the loaded count is at least one; a load restarts the interval at once
`timescale 1ns/1ns
module interval_timer #(
  parameter int unsigned W = 32
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // control
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  // status
  output logic o_done
);

  typedef struct packed {
    logic [W-1:0] remaining;
  } state_t;

  state_t s_reg;
  state_t s_next;

  generate
    if (W < 2)
    begin : g_chk
      $error("interval_timer: W must be at least 2");
    end
  endgenerate

  always_comb
  begin
    s_next = s_reg;
    if (i_load)
    begin
      s_next.remaining = i_count;
    end
    else if (s_reg.remaining != '0)
    begin
      s_next.remaining = s_reg.remaining - W'(1);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_done = (s_reg.remaining == W'(1));

endmodule // interval_timer

// ### src/fault_history.sv
// fault history log, cleared by reset, with a per-code occurrence count
// assumes at most one log request per cycle; the oldest slot is overwritten when full
`timescale 1ns/1ns
module fault_history #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned CODE_W = 16,
  parameter int unsigned COUNT_W = 8
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // log write
  input wire logic i_log_valid,
  input wire logic [CODE_W-1:0] i_log_code,
  input wire logic i_log_shutdown,
  // service read
  input wire logic [$clog2(DEPTH)-1:0] i_rd_idx,
  output logic o_rd_used,
  output logic o_rd_shutdown,
  output logic [CODE_W-1:0] o_rd_code,
  output logic [COUNT_W-1:0] o_rd_count
);

  localparam int unsigned IDX_W = $clog2(DEPTH);

  typedef struct packed {
    logic used;
    logic shut;
    logic [CODE_W-1:0] code;
    logic [COUNT_W-1:0] count;
  } entry_t;

  typedef struct packed {
    entry_t [DEPTH-1:0] ent;
    logic [IDX_W-1:0] wr_ptr;
    entry_t rd;
  } state_t;

  state_t s_reg;
  state_t s_next;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || COUNT_W < 1)
    begin : g_chk
      $error("fault_history: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  always_comb
  begin
    logic found;
    logic [IDX_W-1:0] hit;
    found = 1'b0;
    hit = '0;
    s_next = s_reg;
    for (int i = 0; i < DEPTH; i++)
    begin
      if (!found && s_reg.ent[i].used && s_reg.ent[i].code == i_log_code && s_reg.ent[i].shut == i_log_shutdown)
      begin
        found = 1'b1;
        hit = IDX_W'(i);
      end
    end
    if (i_log_valid)
    begin
      if (found)
      begin
        // count saturates rather than wrapping back to a misleading small value
        if (s_reg.ent[hit].count != '1)
        begin
          s_next.ent[hit].count = s_reg.ent[hit].count + COUNT_W'(1);
        end
      end
      else
      begin
        s_next.ent[s_reg.wr_ptr].used = 1'b1;
        s_next.ent[s_reg.wr_ptr].shut = i_log_shutdown;
        s_next.ent[s_reg.wr_ptr].code = i_log_code;
        s_next.ent[s_reg.wr_ptr].count = COUNT_W'(1);
        s_next.wr_ptr = s_reg.wr_ptr + IDX_W'(1);
      end
    end
    s_next.rd = s_reg.ent[i_rd_idx];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_rd_used = s_reg.rd.used;
  assign o_rd_shutdown = s_reg.rd.shut;
  assign o_rd_code = s_reg.rd.code;
  assign o_rd_count = s_reg.rd.count;

endmodule // fault_history

// ### src/fault_blink_code_indicator.sv
// status lamp annunciator, active fault record, history log and operator panel outputs
// assumes synchronous level inputs from the controller core and one-cycle fault and ack pulses
`timescale 1ns/1ns

module fault_blink_code_indicator #(
  parameter int unsigned PULSE_ON_CYC = fault_blink_pkg::PULSE_ON_CYC,
  parameter int unsigned PULSE_OFF_CYC = fault_blink_pkg::PULSE_OFF_CYC,
  parameter int unsigned DIGIT_GAP_CYC = fault_blink_pkg::DIGIT_GAP_CYC,
  parameter int unsigned CODE_GAP_CYC = fault_blink_pkg::CODE_GAP_CYC,
  parameter int unsigned START_BLINK_CYC = fault_blink_pkg::START_BLINK_CYC,
  parameter int unsigned HIST_DEPTH = fault_blink_pkg::HIST_DEPTH
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // genset state
  input wire logic i_preheat,
  input wire logic i_starting,
  input wire logic i_running,
  // fault events
  input wire logic i_fault_valid,
  input wire logic i_fault_shutdown,
  input wire logic [fault_blink_pkg::CODE_W-1:0] i_fault_code,
  input wire logic i_fault_ack,
  // switch and panel
  input wire logic i_switch_off,
  input wire logic i_panel_fitted,
  input wire logic i_panel_off_btn,
  input wire logic i_run_request,
  // service tool read
  input wire logic [$clog2(HIST_DEPTH)-1:0] i_svc_idx,
  // lamp and panel outputs
  output logic o_status_lamp,
  output logic o_warn_led,
  output logic o_shutdown_led,
  output logic o_disp_valid,
  output logic [fault_blink_pkg::CODE_W-1:0] o_disp_code,
  output logic o_off_mode,
  // service tool outputs
  output logic o_svc_warn_valid,
  output logic [fault_blink_pkg::CODE_W-1:0] o_svc_warn_code,
  output logic o_svc_used,
  output logic o_svc_shutdown,
  output logic [fault_blink_pkg::CODE_W-1:0] o_svc_code,
  output logic [fault_blink_pkg::COUNT_W-1:0] o_svc_count
);

  localparam int unsigned TW = fault_blink_pkg::TIMER_W;
  localparam int unsigned CW = fault_blink_pkg::CODE_W;
  localparam int unsigned DW = fault_blink_pkg::DIGIT_W;

  typedef struct packed {
    fault_blink_pkg::lamp_seq_t seq;
    logic [1:0] digit_idx;
    logic [3:0] pulses;
    logic [CW-1:0] snap;
    logic sd_valid;
    logic [CW-1:0] sd_code;
    logic sd_ind;
    logic wn_valid;
    logic [CW-1:0] wn_code;
    logic wn_pend;
    logic [CW-1:0] wn_pend_code;
    logic log_valid;
    logic log_shut;
    logic [CW-1:0] log_code;
    logic blink;
    logic blink_run;
    logic off_mode;
    logic lamp;
    logic warn_led;
    logic shut_led;
    logic disp_valid;
    logic [CW-1:0] disp_code;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic seq_load;
  logic [TW-1:0] seq_count;
  logic seq_done;
  logic blink_load;
  logic blink_done;

  generate
    if (PULSE_ON_CYC < 1 || PULSE_OFF_CYC < 1 || START_BLINK_CYC < 1 ||
        PULSE_ON_CYC + PULSE_OFF_CYC >= DIGIT_GAP_CYC || DIGIT_GAP_CYC >= CODE_GAP_CYC)
    begin : g_chk
      $error("fault_blink_code_indicator: pulse times must be nonzero and shorter than the gaps");
    end
  endgenerate

  // digit at a position, most significant is index 3
  function automatic logic [DW-1:0] digit_at(input logic [CW-1:0] code, input logic [1:0] idx);
    digit_at = code[idx*DW +: DW];
  endfunction

  // a zero digit would be invisible, so it goes out as ten pulses
  function automatic logic [3:0] pulses_of(input logic [DW-1:0] d);
    pulses_of = (d == '0) ? fault_blink_pkg::ZERO_DIGIT_PULSES : d;
  endfunction

  // leading zeros are skipped; an all-zero code still shows one digit
  function automatic logic [1:0] first_digit(input logic [CW-1:0] code);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 0; i < fault_blink_pkg::CODE_DIGITS; i++)
    begin
      if (code[i*DW +: DW] != '0)
      begin
        idx = 2'(i);
      end
    end
    first_digit = idx;
  endfunction

  always_comb
  begin
    s_next = s_reg;
    seq_load = 1'b0;
    seq_count = TW'(PULSE_ON_CYC);
    blink_load = 1'b0;
    s_next.log_valid = 1'b0;

    // active fault memory; acknowledge logs, a fault in the same cycle still lands
    if (s_reg.wn_pend)
    begin
      s_next.log_valid = 1'b1;
      s_next.log_shut = 1'b0;
      s_next.log_code = s_reg.wn_pend_code;
      s_next.wn_pend = 1'b0;
    end
    if (i_fault_ack)
    begin
      if (s_reg.sd_valid)
      begin
        s_next.log_valid = 1'b1;
        s_next.log_shut = 1'b1;
        s_next.log_code = s_reg.sd_code;
        s_next.wn_pend = s_reg.wn_valid;
        s_next.wn_pend_code = s_reg.wn_code;
      end
      else if (s_reg.wn_valid)
      begin
        s_next.log_valid = 1'b1;
        s_next.log_shut = 1'b0;
        s_next.log_code = s_reg.wn_code;
      end
      s_next.sd_valid = 1'b0;
      s_next.wn_valid = 1'b0;
      s_next.sd_ind = 1'b0;
    end
    if (i_switch_off)
    begin
      s_next.sd_ind = 1'b0;
    end
    if (i_fault_valid)
    begin
      if (i_fault_shutdown)
      begin
        s_next.sd_valid = 1'b1;
        s_next.sd_code = i_fault_code;
        s_next.sd_ind = 1'b1;
      end
      else
      begin
        s_next.wn_valid = 1'b1;
        s_next.wn_code = i_fault_code;
      end
    end

    // off mode from the panel button; a later run request leaves it
    if (i_run_request)
    begin
      s_next.off_mode = 1'b0;
    end
    if (i_panel_fitted && i_panel_off_btn)
    begin
      s_next.off_mode = 1'b1;
    end

    // steady blink for preheat and start
    // the timer sits at zero after reset and never finishes on its own, so it is kicked once
    if (blink_done || !s_reg.blink_run)
    begin
      blink_load = 1'b1;
      s_next.blink_run = 1'b1;
    end
    if (blink_done)
    begin
      s_next.blink = !s_reg.blink;
    end

    // code sequencer
    unique case (s_reg.seq)
      fault_blink_pkg::SEQ_IDLE:
      begin
        if (s_reg.sd_ind)
        begin
          s_next.snap = s_reg.sd_code;
          s_next.digit_idx = first_digit(s_reg.sd_code);
          s_next.pulses = pulses_of(digit_at(s_reg.sd_code, first_digit(s_reg.sd_code)));
          s_next.seq = fault_blink_pkg::SEQ_ON;
          seq_load = 1'b1;
          seq_count = TW'(PULSE_ON_CYC);
        end
      end
      fault_blink_pkg::SEQ_ON:
      begin
        if (seq_done)
        begin
          seq_load = 1'b1;
          if (s_reg.pulses != 4'h1)
          begin
            s_next.pulses = s_reg.pulses - 4'h1;
            s_next.seq = fault_blink_pkg::SEQ_OFF;
            seq_count = TW'(PULSE_OFF_CYC);
          end
          else if (s_reg.digit_idx == 2'h0)
          begin
            s_next.seq = fault_blink_pkg::SEQ_CGAP;
            seq_count = TW'(CODE_GAP_CYC);
          end
          else
          begin
            s_next.seq = fault_blink_pkg::SEQ_DGAP;
            seq_count = TW'(DIGIT_GAP_CYC);
          end
        end
      end
      fault_blink_pkg::SEQ_OFF:
      begin
        if (seq_done)
        begin
          s_next.seq = fault_blink_pkg::SEQ_ON;
          seq_load = 1'b1;
          seq_count = TW'(PULSE_ON_CYC);
        end
      end
      fault_blink_pkg::SEQ_DGAP:
      begin
        if (seq_done)
        begin
          s_next.digit_idx = s_reg.digit_idx - 2'h1;
          s_next.pulses = pulses_of(digit_at(s_reg.snap, s_reg.digit_idx - 2'h1));
          s_next.seq = fault_blink_pkg::SEQ_ON;
          seq_load = 1'b1;
          seq_count = TW'(PULSE_ON_CYC);
        end
      end
      fault_blink_pkg::SEQ_CGAP:
      begin
        if (seq_done)
        begin
          // restart from idle so the newest shutdown code is picked up
          s_next.seq = fault_blink_pkg::SEQ_IDLE;
        end
      end
      default:
      begin
        s_next.seq = fault_blink_pkg::SEQ_IDLE;
      end
    endcase
    if (!s_reg.sd_ind)
    begin
      s_next.seq = fault_blink_pkg::SEQ_IDLE;
    end

    // lamp priority: shutdown code, then start blink, then running
    if (s_reg.sd_ind)
    begin
      s_next.lamp = (s_reg.seq == fault_blink_pkg::SEQ_ON);
    end
    else if (i_preheat || i_starting)
    begin
      s_next.lamp = s_reg.blink;
    end
    else if (i_running)
    begin
      s_next.lamp = 1'b1;
    end
    else
    begin
      s_next.lamp = 1'b0;
    end

    // operator panel
    s_next.shut_led = i_panel_fitted && s_reg.sd_valid;
    s_next.warn_led = i_panel_fitted && s_reg.wn_valid && !s_reg.sd_valid;
    s_next.disp_valid = i_panel_fitted && (s_reg.sd_valid || s_reg.wn_valid);
    s_next.disp_code = s_reg.sd_valid ? s_reg.sd_code : (s_reg.wn_valid ? s_reg.wn_code : '0);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  interval_timer #(
    .W(TW)
  ) u_seq_timer (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_load(seq_load),
    .i_count(seq_count),
    .o_done(seq_done)
  );

  interval_timer #(
    .W(TW)
  ) u_blink_timer (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_load(blink_load),
    .i_count(TW'(START_BLINK_CYC)),
    .o_done(blink_done)
  );

  fault_history #(
    .DEPTH(HIST_DEPTH),
    .CODE_W(CW),
    .COUNT_W(fault_blink_pkg::COUNT_W)
  ) u_history (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_log_valid(s_reg.log_valid),
    .i_log_code(s_reg.log_code),
    .i_log_shutdown(s_reg.log_shut),
    .i_rd_idx(i_svc_idx),
    .o_rd_used(o_svc_used),
    .o_rd_shutdown(o_svc_shutdown),
    .o_rd_code(o_svc_code),
    .o_rd_count(o_svc_count)
  );

  assign o_status_lamp = s_reg.lamp;
  assign o_warn_led = s_reg.warn_led;
  assign o_shutdown_led = s_reg.shut_led;
  assign o_disp_valid = s_reg.disp_valid;
  assign o_disp_code = s_reg.disp_code;
  assign o_off_mode = s_reg.off_mode;
  assign o_svc_warn_valid = s_reg.wn_valid;
  assign o_svc_warn_code = s_reg.wn_code;

endmodule // fault_blink_code_indicator

// ### src/fault_blink_seq_note.sv
// no logic here: the lamp code sequencer lives in the indicator top

// ### testbench/fault_blink_code_indicator_props.sv
// timing checks on the status lamp, panel outputs and off mode
// assumes a bind to the indicator top with its shortened lamp parameters
`timescale 1ns/1ns
module fault_blink_props #(
  parameter int unsigned START_BLINK_CYC = 4
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // watched inputs
  input wire logic i_preheat,
  input wire logic i_starting,
  input wire logic i_running,
  input wire logic i_fault_valid,
  input wire logic i_fault_shutdown,
  input wire logic [fault_blink_pkg::CODE_W-1:0] i_fault_code,
  input wire logic i_fault_ack,
  input wire logic i_switch_off,
  input wire logic i_panel_fitted,
  input wire logic i_panel_off_btn,
  // watched outputs
  input wire logic o_status_lamp,
  input wire logic o_warn_led,
  input wire logic o_shutdown_led,
  input wire logic o_disp_valid,
  input wire logic [fault_blink_pkg::CODE_W-1:0] o_disp_code,
  input wire logic o_off_mode,
  input wire logic o_svc_warn_valid
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // shadow of the lamp shutdown indication; a new fault wins over a same-cycle ack or switch off
  logic sd_reg;
  logic sd_next;
  logic [3:0] sd_age_reg;
  logic [3:0] sd_age_next;
  logic [4:0] blink_reg;
  logic [4:0] blink_next;
  always_comb
  begin
    sd_next = (i_fault_valid && i_fault_shutdown) || (sd_reg && !i_fault_ack && !i_switch_off);
    sd_age_next = sd_reg ? (sd_age_reg + {3'h0, sd_age_reg != 4'hf}) : 4'h0;
    blink_next = ((i_preheat || i_starting) && !sd_reg) ? (blink_reg + {4'h0, blink_reg != 5'h1f}) : 5'h00;
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      sd_reg <= 1'h0;
      sd_age_reg <= 4'h0;
      blink_reg <= 5'h00;
    end
    else
    begin
      sd_reg <= sd_next;
      sd_age_reg <= sd_age_next;
      blink_reg <= blink_next;
    end
  end
  property p_blink; blink_reg >= 5'h0c |-> o_status_lamp != $past(o_status_lamp, START_BLINK_CYC); endproperty
  a_blink: assert property (p_blink) else $error("start blink not steady");
  property p_run_on; (i_running && !i_preheat && !i_starting && !sd_reg)[*4] |=> o_status_lamp; endproperty
  a_run_on: assert property (p_run_on) else $error("lamp not lit while running");
  property p_idle_dark; (!i_preheat && !i_starting && !i_running && !sd_reg)[*3] |=> !o_status_lamp; endproperty
  a_idle_dark: assert property (p_idle_dark) else $error("lamp lit with no shutdown");
  property p_switch_off; (i_switch_off && !i_preheat && !i_starting && !i_running)[*3] |=> !o_status_lamp;
  endproperty
  a_switch_off: assert property (p_switch_off) else $error("switch off left lamp lit");
  // the indication must have stood unbroken, or a run-lit lamp falling into a new code looks like a pulse
  property p_pulse_on; $fell(o_status_lamp) && sd_reg && sd_age_reg >= 4'h8
    |-> $past(o_status_lamp, 2) && $past(o_status_lamp, 3) && !$past(o_status_lamp, 4); endproperty
  a_pulse_on: assert property (p_pulse_on) else $error("code pulse width wrong");
  property p_sd_panel; i_fault_valid && i_fault_shutdown ##1 i_panel_fitted
    |-> ##1 o_shutdown_led && o_disp_valid && o_disp_code == $past(i_fault_code, 2); endproperty
  a_sd_panel: assert property (p_sd_panel) else $error("shutdown panel output wrong");
  property p_warn_panel; i_fault_valid && !i_fault_shutdown ##1 i_panel_fitted |-> ##1 o_warn_led ^ o_shutdown_led;
  endproperty
  a_warn_panel: assert property (p_warn_panel) else $error("warning led class wrong");
  property p_ack; i_fault_ack && !i_fault_valid ##1 !i_fault_valid
    |-> ##1 !o_shutdown_led && !o_warn_led && !o_svc_warn_valid; endproperty
  a_ack: assert property (p_ack) else $error("fault still active after ack");
  property p_off; i_panel_fitted && i_panel_off_btn |=> o_off_mode; endproperty
  a_off: assert property (p_off) else $error("off button ignored");
endmodule // fault_blink_props

// ### testbench/lamp_reader.sv
// operator reading the status lamp: counts flashes back into a four-digit code
// assumes the bench's short timing: pulse gaps of 3, digit gaps near 10, code gaps of 20 or more
`timescale 1ns/1ns
module lamp_reader #(
  parameter int unsigned DGAP_MIN = 8,
  parameter int unsigned CGAP_MIN = 16
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // lamp
  input wire logic i_lamp,
  // decoded code, valid at the start of the following frame
  output logic o_code_valid,
  output logic [15:0] o_code
);
  logic [7:0] dark_reg;
  logic [3:0] pulses_reg;
  logic [15:0] acc_reg;
  logic [3:0] digit;
  // ten flashes stand for a zero digit
  assign digit = (pulses_reg == 4'ha) ? 4'h0 : pulses_reg;
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      dark_reg <= 8'h00;
      pulses_reg <= 4'h0;
      acc_reg <= 16'h0000;
      o_code <= 16'h0000;
      o_code_valid <= 1'h0;
    end
    else
    begin
      o_code_valid <= 1'h0;
      if (i_lamp && dark_reg != 8'h00)
      begin
        pulses_reg <= 4'h1;
        if (32'(dark_reg) >= CGAP_MIN)
        begin
          o_code <= {acc_reg[11:0], digit};
          o_code_valid <= 1'h1;
          acc_reg <= 16'h0000;
        end
        else if (32'(dark_reg) >= DGAP_MIN)
          acc_reg <= {acc_reg[11:0], digit};
        else
          pulses_reg <= pulses_reg + 4'h1;
      end
      if (i_lamp)
        dark_reg <= 8'h00;
      else if (dark_reg != 8'hff)
        dark_reg <= dark_reg + 8'h01;
    end
  end
endmodule // lamp_reader

// ### testbench/test_fault_blink_code_indicator.sv
// self-checking bench for the fault blink-code indicator with a lamp reader partner
// assumes shortened lamp timing so one code frame takes a few hundred cycles
`timescale 1ns/1ns
module test_fault_blink_code_indicator;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic pre = 1'h0, sta = 1'h0, run = 1'h0, fv = 1'h0, fsd = 1'h0, ack = 1'h0;
  logic swo = 1'h0, pfit = 1'h0, obtn = 1'h0, rreq = 1'h0;
  logic [15:0] fcode = 16'h0000;
  logic [3:0] sidx = 4'h0;
  logic lamp, wled, sled, dval, offm, swv, sused, ssd, cval;
  logic [15:0] dcode, swc, scode, rcode, code;
  logic [7:0] scnt;
  int bad_count = 0, n_tests = 0, cyc = 0, seed = 5, i, k;
  always #2 clk = ~clk;
  fault_blink_code_indicator #(.PULSE_ON_CYC(3), .PULSE_OFF_CYC(3), .DIGIT_GAP_CYC(10), .CODE_GAP_CYC(20),
    .START_BLINK_CYC(4), .HIST_DEPTH(16)) dut_u (.i_ref_clk(clk), .i_resetn(rstn), .i_preheat(pre),
    .i_starting(sta), .i_running(run), .i_fault_valid(fv), .i_fault_shutdown(fsd), .i_fault_code(fcode),
    .i_fault_ack(ack), .i_switch_off(swo), .i_panel_fitted(pfit), .i_panel_off_btn(obtn), .i_run_request(rreq),
    .i_svc_idx(sidx), .o_status_lamp(lamp), .o_warn_led(wled), .o_shutdown_led(sled), .o_disp_valid(dval),
    .o_disp_code(dcode), .o_off_mode(offm), .o_svc_warn_valid(swv), .o_svc_warn_code(swc), .o_svc_used(sused),
    .o_svc_shutdown(ssd), .o_svc_code(scode), .o_svc_count(scnt));
  lamp_reader reader_u (.i_ref_clk(clk), .i_resetn(rstn), .i_lamp(lamp), .o_code_valid(cval), .o_code(rcode));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic fire(input logic [15:0] c, input logic sd);
    @(posedge clk);
    fv <= 1'h1;
    fsd <= sd;
    fcode <= c;
    @(posedge clk);
    fv <= 1'h0;
  endtask
  // one-cycle strobe on ack (0), the Off button (1) or a run request (2)
  task automatic pulse(input int sel);
    @(posedge clk);
    case (sel)
      0: ack <= 1'h1;
      1: obtn <= 1'h1;
      default: rreq <= 1'h1;
    endcase
    @(posedge clk);
    ack <= 1'h0;
    obtn <= 1'h0;
    rreq <= 1'h0;
  endtask
  // waits for published frames until the wanted code shows, at most four of them
  task automatic wait_match(input logic [15:0] c);
    for (k = 0; k < 4 && rcode !== c; k++)
    begin
      @(negedge clk);
      while (cval !== 1'h1)
        @(negedge clk);
    end
  endtask
  function automatic logic [15:0] rand_code();
    logic [15:0] c;
    c[15:12] = 4'h1 + 4'($unsigned($random(seed)) % 9);
    for (int d = 0; d < 3; d++)
      c[d*4 +: 4] = 4'($unsigned($random(seed)) % 10);
    return c;
  endfunction
  // one repeat of the same shutdown code bumps the count, the warning gets a fresh slot
  function automatic logic [15:0] exp_count(input int slot);
    return (slot == 0) ? 16'h0002 : 16'h0001;
  endfunction
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    idle(3);
    rstn <= 1'h1;
    pre <= 1'h1;
    idle(30);
    pre <= 1'h0;
    sta <= 1'h1;
    idle(30);
    sta <= 1'h0;
    run <= 1'h1;
    idle(10);
    @(negedge clk);
    chk_bit(lamp, 1'h1);
    idle(1);
    run <= 1'h0;
    pfit <= 1'h1;
    code = rand_code();
    fire(code, 1'h0);
    idle(8);
    @(negedge clk);
    chk_bit(lamp, 1'h0);
    chk_code(swc, code);
    chk_bit(wled, 1'h1);
    $display("test lamp states done");
    for (i = 0; i < 6; i++)
    begin
      code = (i == 0) ? 16'h0203 : (i == 1) ? 16'h9999 : rand_code();
      idle(1);
      run <= 1'($random(seed));
      fire(rand_code(), 1'h1);
      fire(code, 1'h1);
      wait_match(code);
      chk_code(rcode, code);
      chk_code(dcode, code);
      chk_bit(wled, 1'h0);
      wait_match(~code);
      chk_code(rcode, code);
      if (i < 5)
      begin
        pulse(0);
        idle(3);
        @(negedge clk);
        chk_bit(sled, 1'h0);
      end
    end
    idle(1);
    run <= 1'h0;
    swo <= 1'h1;
    idle(4);
    swo <= 1'h0;
    repeat (40)
    begin
      @(negedge clk);
      chk_bit(lamp, 1'h0);
    end
    $display("test shutdown codes done");
    idle(1);
    rstn <= 1'h0;
    idle(3);
    rstn <= 1'h1;
    code = rand_code();
    for (i = 0; i < 3; i++)
    begin
      fire((i == 2) ? ~code : code, i != 2);
      pulse(0);
    end
    for (i = 0; i < 3; i++)
    begin
      idle(4);
      sidx <= 4'(i);
      idle(2);
      @(negedge clk);
      chk_bit(sused, i != 2);
      if (i < 2)
      begin
        chk_bit(ssd, i == 0);
        chk_code(scode, (i == 1) ? ~code : code);
        chk_code({8'h00, scnt}, exp_count(i));
      end
    end
    $display("test history done");
    pulse(1);
    idle(1);
    @(negedge clk);
    chk_bit(offm, 1'h1);
    pulse(2);
    idle(1);
    @(negedge clk);
    chk_bit(offm, 1'h0);
    $display("test off mode done");
    give_verdict();
  end
endmodule // test_fault_blink_code_indicator
bind fault_blink_code_indicator fault_blink_props #(.START_BLINK_CYC(START_BLINK_CYC)) props_u (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_preheat(i_preheat), .i_starting(i_starting),
  .i_running(i_running), .i_fault_valid(i_fault_valid), .i_fault_shutdown(i_fault_shutdown),
  .i_fault_code(i_fault_code), .i_fault_ack(i_fault_ack), .i_switch_off(i_switch_off),
  .i_panel_fitted(i_panel_fitted), .i_panel_off_btn(i_panel_off_btn), .o_status_lamp(o_status_lamp),
  .o_warn_led(o_warn_led), .o_shutdown_led(o_shutdown_led), .o_disp_valid(o_disp_valid),
  .o_disp_code(o_disp_code), .o_off_mode(o_off_mode), .o_svc_warn_valid(o_svc_warn_valid));
